/* File: include/reg_func_consts.vh */
// Constants for the register function handler.
// What this block does
// - Mask write success echoes function, address, masks
// - Errors use function | 0x80 (0x96/0x97/0x98/0xab) plus exception code
// - Combined function writes before it reads
// - Holding register addresses are zero-based
// - Read qty 1..0x7d, write qty 1..0x79
// - Combined response: 0x17, count, ascending registers
// - Queue reply: count first, at most 31 data
// - Queue read never removes queued entries
// - Queue byte count covers count and data
// - Queue count excludes the count register
// - Queue count above 31 gives exception 03
// - Queue data follows pointer, ascending order
// - Only MEI types 13 and 14 defined
// - MEI type byte routes request to handler
// - Interface handler owns its own errors
// - Masked value is (cur&and)|(or&~and), stored
// - Mask reply only after register updated
`ifndef REG_FUNC_CONSTS_VH
`define REG_FUNC_CONSTS_VH
`define FC_MASK_WR      8'h16
`define FC_RW_MULTI     8'h17
`define FC_QUEUE_RD     8'h18
`define FC_ENCAP        8'h2b
`define FC_ERR_BIT      8'h80
`define EXC_ILL_FUNC    8'h01
`define EXC_ILL_ADDR    8'h02
`define EXC_ILL_VALUE   8'h03
`define RD_QTY_MAX      16'h007d
`define WR_QTY_MAX      16'h0079
`define QUEUE_MAX       16'h001f
`define MEI_TYPE_A      8'h0d
`define MEI_TYPE_B      8'h0e
`define REG_ADDR_W      8
`define FIFO_DEPTH      32
`define FIFO_AW         5
`endif

/* File: logic/byte_fifo.v */
// Synchronous valid/ready FIFO used on the response byte stream.
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clocking.
  input  wire             core_clk,
  input  wire             rstn,
  input  wire             clk_en,
  // Fill side.
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side.
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_r];
  assign push      = clk_en & in_valid & in_ready;
  assign pop       = clk_en & out_valid & out_ready;

  // Storage has no reset; only pointers and the count need a defined value.
  always @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  // Pointer and count update.
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push & ~pop)
        count_r <= count_r + 1'b1;
      else if (pop & ~push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: logic/reg_bank.v */
// Holding register bank with one synchronous write and one read port.
`timescale 1ns/10ps
`default_nettype none
module reg_bank #(
  parameter AW = 8
) (
  // Clocking.
  input  wire          core_clk,
  input  wire          clk_en,
  // Write port.
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [15:0]   wr_data,
  // Read port, combinational.
  input  wire [AW-1:0] rd_addr,
  output wire [15:0]   rd_data
);
  reg [15:0] regs [0:(1<<AW)-1];

  // A write lands at the edge; a read of the same word sees it next cycle.
  always @(posedge core_clk)
  begin
    if (clk_en & wr_en)
      regs[wr_addr] <= wr_data;
  end

  assign rd_data = regs[rd_addr];
endmodule
`default_nettype wire

/* File: logic/register_function_handler.v */
// Request interpreter for mask write, combined read/write, queue read and MEI transport.
`timescale 1ns/10ps
`default_nettype none
`include "reg_func_consts.vh"
module register_function_handler (
  // Clocking and reset.
  input  wire       core_clk,
  input  wire       rstn,
  input  wire       clk_en,
  // Request byte stream from the network stack.
  input  wire       req_valid,
  output reg        req_ready,
  input  wire [7:0] req_data,
  input  wire       req_last,
  // Response byte stream to the network stack.
  output reg        rsp_valid,
  input  wire       rsp_ready,
  output reg  [7:0] rsp_data,
  output reg        rsp_last,
  // Forward path to external MEI interface handlers.
  output reg        mei_valid,
  output reg  [7:0] mei_type,
  output reg  [7:0] mei_data,
  output reg        mei_last,
  output reg        mei_sel_b
);
  // Parser and responder states.
  localparam ST_FUNC  = 4'd0;
  localparam ST_HDR   = 4'd1;
  localparam ST_WDATA = 4'd2;
  localparam ST_DRAIN = 4'd3;
  localparam ST_EXEC  = 4'd4;
  localparam ST_RSP   = 4'd5;
  localparam ST_ERR   = 4'd6;
  localparam ST_MEI   = 4'd7;
  localparam ST_MASK  = 4'd8;

  reg  [3:0]  state_r;
  reg  [7:0]  func_r;
  reg  [3:0]  hdr_idx_r;
  reg  [7:0]  hdr_r [0:8];
  reg  [7:0]  wr_cnt_r;
  reg  [7:0]  wr_hi_r;
  reg         wr_odd_r;
  reg  [15:0] wr_ptr_r;
  reg  [7:0]  exc_r;
  reg  [7:0]  out_idx_r;
  reg  [7:0]  out_len_r;
  reg  [15:0] rd_ptr_r;
  reg  [15:0] q_cnt_r;
  reg         last_seen_r;

  // Register bank ports.
  reg         bank_we;
  reg  [15:0] bank_wd;
  reg  [7:0]  bank_wa;
  reg  [7:0]  bank_ra;
  wire [15:0] bank_rd;

  // Response FIFO fill side.
  reg         f_valid;
  reg  [7:0]  f_data;
  wire        f_ready;
  wire        f_out_valid;
  wire [7:0]  f_out_data;
  reg         f_last_r;

  // Header words assembled from the received bytes, high byte first.
  wire [15:0] w0 = {hdr_r[0], hdr_r[1]};
  wire [15:0] w1 = {hdr_r[2], hdr_r[3]};
  wire [15:0] w2 = {hdr_r[4], hdr_r[5]};
  wire [15:0] w3 = {hdr_r[6], hdr_r[7]};

  // Header length in bytes after the function code.
  function [3:0] hdr_len;
    input [7:0] fc;
    begin
      case (fc)
        `FC_MASK_WR:  hdr_len = 4'd6;
        `FC_RW_MULTI: hdr_len = 4'd9;
        `FC_QUEUE_RD: hdr_len = 4'd2;
        default:      hdr_len = 4'd1;
      endcase
    end
  endfunction

  // True when a 16-bit PDU address falls inside the local bank.
  function in_bank;
    input [15:0] a;
    begin
      in_bank = (a[15:`REG_ADDR_W] == {(16-`REG_ADDR_W){1'b0}});
    end
  endfunction

  reg_bank #(
    .AW (`REG_ADDR_W)
  ) u_bank (
    .core_clk (core_clk),
    .clk_en   (clk_en),
    .wr_en    (bank_we),
    .wr_addr  (bank_wa),
    .wr_data  (bank_wd),
    .rd_addr  (bank_ra),
    .rd_data  (bank_rd)
  );

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .clk_en    (clk_en),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_data),
    .out_valid (f_out_valid),
    .out_ready (rsp_ready | ~rsp_valid),
    .out_data  (f_out_data)
  );

  // Byte at position out_idx_r of the current normal response.
  reg [7:0] rsp_byte;
  reg [15:0] wr_ofs;
  always @*
  begin
    rsp_byte = 8'h00;
    wr_ofs   = 16'h0000;
    bank_we  = 1'b0;
    bank_wa  = 8'h00;
    bank_wd  = 16'h0000;
    bank_ra  = rd_ptr_r[7:0];
    if (func_r == `FC_MASK_WR)
    begin
      // Echo of the request: function, address, and masks.
      if (out_idx_r == 8'd0)
        rsp_byte = func_r;
      else
        rsp_byte = hdr_r[out_idx_r[3:0] - 4'd1];
    end
    else if (func_r == `FC_RW_MULTI)
    begin
      if (out_idx_r == 8'd0)
        rsp_byte = func_r;
      else if (out_idx_r == 8'd1)
        rsp_byte = {w1[6:0], 1'b0};
      else
        rsp_byte = out_idx_r[0] ? bank_rd[7:0] : bank_rd[15:8];
    end
    else if (func_r == `FC_QUEUE_RD)
    begin
      // Byte count covers the count word and the data words only.
      case (out_idx_r)
        8'd0:    rsp_byte = func_r;
        8'd1:    rsp_byte = 8'h00;
        8'd2:    rsp_byte = {q_cnt_r[6:0], 1'b0} + 8'd2;
        8'd3:    rsp_byte = q_cnt_r[15:8];
        8'd4:    rsp_byte = q_cnt_r[7:0];
        default: rsp_byte = out_idx_r[0] ? bank_rd[15:8] : bank_rd[7:0];
      endcase
    end
    // A completed write word from the combined request.
    if (state_r == ST_WDATA && wr_odd_r && req_valid && req_ready && clk_en)
    begin
      wr_ofs  = w2 + wr_ptr_r;
      bank_we = 1'b1;
      bank_wa = wr_ofs[7:0];
      bank_wd = {wr_hi_r, req_data};
    end
    else if (state_r == ST_MASK)
    begin
      bank_ra = w0[7:0];
      bank_we = 1'b1;
      bank_wa = w0[7:0];
      bank_wd = (bank_rd & w1) | (w2 & ~w1);
    end
  end

  // Main sequencer: parse, execute, then stream the answer into the FIFO.
  integer i;
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r     <= ST_FUNC;
      func_r      <= 8'h00;
      hdr_idx_r   <= 4'd0;
      for (i = 0; i < 9; i = i + 1)
        hdr_r[i] <= 8'h00;
      wr_cnt_r    <= 8'h00;
      wr_hi_r     <= 8'h00;
      wr_odd_r    <= 1'b0;
      wr_ptr_r    <= 16'h0000;
      exc_r       <= 8'h00;
      out_idx_r   <= 8'h00;
      out_len_r   <= 8'h00;
      rd_ptr_r    <= 16'h0000;
      q_cnt_r     <= 16'h0000;
      last_seen_r <= 1'b0;
      req_ready   <= 1'b0;
      f_valid     <= 1'b0;
      f_data      <= 8'h00;
      f_last_r    <= 1'b0;
      mei_valid   <= 1'b0;
      mei_type    <= 8'h00;
      mei_data    <= 8'h00;
      mei_last    <= 1'b0;
      mei_sel_b   <= 1'b0;
    end
    else if (clk_en)
    begin
      mei_valid <= 1'b0;
      if (f_valid && f_ready)
        f_valid <= 1'b0;
      case (state_r)
        ST_FUNC:
        begin
          req_ready <= 1'b1;
          if (req_valid && req_ready)
          begin
            func_r      <= req_data;
            hdr_idx_r   <= 4'd0;
            wr_ptr_r    <= 16'h0000;
            wr_odd_r    <= 1'b0;
            last_seen_r <= 1'b1;
            state_r     <= req_last ? ST_ERR : ST_HDR;
            exc_r       <= `EXC_ILL_VALUE;
            if (req_data != `FC_MASK_WR && req_data != `FC_RW_MULTI &&
                req_data != `FC_QUEUE_RD && req_data != `FC_ENCAP)
            begin
              exc_r   <= `EXC_ILL_FUNC;
              state_r <= req_last ? ST_ERR : ST_DRAIN;
            end
          end
        end
        ST_HDR:
        begin
          if (req_valid && req_ready)
          begin
            hdr_r[hdr_idx_r] <= req_data;
            hdr_idx_r        <= hdr_idx_r + 4'd1;
            if (func_r == `FC_ENCAP)
            begin
              // Only the two assigned interface types are passed on.
              mei_type  <= req_data;
              mei_sel_b <= (req_data == `MEI_TYPE_B);
              if (req_data == `MEI_TYPE_A || req_data == `MEI_TYPE_B)
                state_r <= req_last ? ST_FUNC : ST_MEI;
              else
              begin
                exc_r   <= `EXC_ILL_FUNC;
                state_r <= req_last ? ST_ERR : ST_DRAIN;
              end
            end
            else if (hdr_idx_r == hdr_len(func_r) - 4'd1)
            begin
              if (func_r == `FC_RW_MULTI)
              begin
                // Header order: read addr, read qty, write addr, write qty, count.
                if (w1 == 16'h0000 || w1 > `RD_QTY_MAX || w3 == 16'h0000 ||
                    w3 > `WR_QTY_MAX || req_data != {w3[6:0], 1'b0})
                  state_r <= req_last ? ST_ERR : ST_DRAIN;
                else if (!in_bank(w0 + w1 - 16'd1) || !in_bank(w2 + w3 - 16'd1) ||
                         !in_bank(w0) || !in_bank(w2))
                begin
                  exc_r   <= `EXC_ILL_ADDR;
                  state_r <= req_last ? ST_ERR : ST_DRAIN;
                end
                else
                begin
                  wr_cnt_r <= req_data;
                  state_r  <= req_last ? ST_ERR : ST_WDATA;
                end
              end
              else if (!req_last)
                state_r <= ST_DRAIN;
              else if (func_r == `FC_MASK_WR && !in_bank(w0))
              begin
                exc_r   <= `EXC_ILL_ADDR;
                state_r <= ST_ERR;
              end
              else if (func_r == `FC_MASK_WR)
              begin
                req_ready <= 1'b0;
                state_r   <= ST_MASK;
              end
              else
              begin
                // Queue read: pointer address, then count from that register.
                rd_ptr_r  <= {hdr_r[0], req_data};
                req_ready <= 1'b0;
                state_r   <= in_bank({hdr_r[0], req_data}) ? ST_EXEC : ST_ERR;
                exc_r     <= `EXC_ILL_ADDR;
              end
            end
            else if (req_last)
              state_r <= ST_ERR;
          end
        end
        ST_WDATA:
        begin
          // Writes land fully before any read word is produced.
          if (req_valid && req_ready)
          begin
            wr_hi_r  <= req_data;
            wr_odd_r <= ~wr_odd_r;
            wr_cnt_r <= wr_cnt_r - 8'd1;
            if (wr_odd_r)
              wr_ptr_r <= wr_ptr_r + 16'd1;
            if (req_last)
            begin
              req_ready <= 1'b0;
              rd_ptr_r  <= w0;
              out_idx_r <= 8'd0;
              out_len_r <= {w1[6:0], 1'b0} + 8'd2;
              state_r   <= (wr_cnt_r == 8'd1) ? ST_RSP : ST_ERR;
            end
          end
        end
        ST_MASK:
        begin
          // Write happens this edge; the echo starts afterwards.
          out_idx_r <= 8'd0;
          out_len_r <= 8'd7;
          state_r   <= ST_RSP;
        end
        ST_EXEC:
        begin
          q_cnt_r   <= bank_rd;
          rd_ptr_r  <= rd_ptr_r + 16'd1;
          out_idx_r <= 8'd0;
          exc_r     <= `EXC_ILL_VALUE;
          if (bank_rd > `QUEUE_MAX || !in_bank(rd_ptr_r + bank_rd))
            state_r <= ST_ERR;
          else
          begin
            out_len_r <= {bank_rd[6:0], 1'b0} + 8'd5;
            state_r   <= ST_RSP;
          end
        end
        ST_RSP:
        begin
          if (!f_valid || f_ready)
          begin
            f_valid   <= 1'b1;
            f_data    <= rsp_byte;
            f_last_r  <= (out_idx_r == out_len_r - 8'd1);
            out_idx_r <= out_idx_r + 8'd1;
            // Advance through registers in ascending order.
            if (func_r == `FC_QUEUE_RD ? (out_idx_r >= 8'd6 && !out_idx_r[0]) :
                (out_idx_r >= 8'd3 && out_idx_r[0]))
              rd_ptr_r <= rd_ptr_r + 16'd1;
            if (out_idx_r == out_len_r - 8'd1)
            begin
              state_r   <= ST_FUNC;
              req_ready <= 1'b1;
            end
          end
        end
        ST_DRAIN:
        begin
          if (req_valid && req_ready && req_last)
            state_r <= ST_ERR;
        end
        ST_MEI:
        begin
          // Payload is forwarded untouched; the handler answers and checks.
          if (req_valid && req_ready)
          begin
            mei_valid <= 1'b1;
            mei_data  <= req_data;
            mei_last  <= req_last;
            if (req_last)
              state_r <= ST_FUNC;
          end
        end
        ST_ERR:
        begin
          // Two-byte exception: function with top bit set, then the code.
          req_ready <= 1'b0;
          if (!f_valid || f_ready)
          begin
            f_valid  <= 1'b1;
            f_data   <= last_seen_r ? (func_r | `FC_ERR_BIT) : exc_r;
            f_last_r <= ~last_seen_r;
            if (!last_seen_r)
            begin
              state_r   <= ST_FUNC;
              req_ready <= 1'b1;
            end
            last_seen_r <= 1'b0;
          end
        end
        default:
          state_r <= ST_FUNC;
      endcase
    end
  end

  // Last-byte marks travel in a small shadow FIFO; a bit per slot suffices.
  reg [`FIFO_DEPTH-1:0] last_q_r;
  reg [`FIFO_AW-1:0]    lq_wr_r;
  reg [`FIFO_AW-1:0]    lq_rd_r;
  wire                  f_pop = clk_en & f_out_valid & (rsp_ready | ~rsp_valid);

  // Output register stage so every port comes from a flop.
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_last  <= 1'b0;
      last_q_r  <= {`FIFO_DEPTH{1'b0}};
      lq_wr_r   <= {`FIFO_AW{1'b0}};
      lq_rd_r   <= {`FIFO_AW{1'b0}};
    end
    else if (clk_en)
    begin
      if (f_valid && f_ready)
      begin
        last_q_r[lq_wr_r] <= f_last_r;
        lq_wr_r           <= lq_wr_r + 1'b1;
      end
      if (f_pop)
      begin
        rsp_valid <= 1'b1;
        rsp_data  <= f_out_data;
        rsp_last  <= last_q_r[lq_rd_r];
        lq_rd_r   <= lq_rd_r + 1'b1;
      end
      else if (rsp_ready)
        rsp_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: dv/register_function_handler_properties.sv */
// Checker for the response and forward streams of the register function handler.
`timescale 1ns/10ps
`default_nettype none
module rfh_checker (
  // Clocking.
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       clk_en,
  // Request stream.
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [7:0] req_data,
  input wire logic       req_last,
  // Response stream.
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_last,
  // Forward path.
  input wire logic       mei_valid,
  input wire logic [7:0] mei_type,
  input wire logic [7:0] mei_data,
  input wire logic       mei_last,
  input wire logic       mei_sel_b
);
  logic [7:0]  req_idx_r;
  logic [7:0]  rsp_idx_r;
  logic [7:0]  fc_r;
  logic [7:0]  bc_r;
  logic [15:0] rq_r;
  logic        err_r;
  // Byte positions let each field be judged by its place in the frame.
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_idx_r <= 8'h00;
      rsp_idx_r <= 8'h00;
      fc_r      <= 8'h00;
      bc_r      <= 8'h00;
      rq_r      <= 16'h0000;
      err_r     <= 1'b0;
    end
    else if (clk_en)
    begin
      if (req_valid && req_ready)
      begin
        req_idx_r <= req_last ? 8'h00 : req_idx_r + 8'h01;
        if (req_idx_r == 8'h00) fc_r <= req_data;
        if (req_idx_r == 8'h03) rq_r[15:8] <= req_data;
        if (req_idx_r == 8'h04) rq_r[7:0] <= req_data;
      end
      if (rsp_valid && rsp_ready)
      begin
        rsp_idx_r <= rsp_last ? 8'h00 : rsp_idx_r + 8'h01;
        if (rsp_idx_r == 8'h00) err_r <= rsp_data[7];
        if (rsp_idx_r == 8'h02) bc_r <= rsp_data;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("response byte moved before it was taken");
  rsp_func_a: assert property (rsp_valid && rsp_idx_r == 8'h00 |->
    rsp_data == fc_r || rsp_data == (fc_r | 8'h80)) else $error("wrong function byte");
  exc_code_a: assert property (rsp_valid && rsp_idx_r == 8'h01 && err_r |->
    rsp_last && rsp_data inside {8'h01, 8'h02, 8'h03, 8'h04}) else $error("bad exception");
  mask_echo_a: assert property (rsp_valid && rsp_last && fc_r == 8'h16 && !err_r |->
    rsp_idx_r == 8'h06) else $error("mask echo length wrong");
  rw_count_a: assert property (rsp_valid && rsp_idx_r == 8'h01 && fc_r == 8'h17 && !err_r |->
    rsp_data == {rq_r[6:0], 1'b0}) else $error("combined byte count wrong");
  rw_len_a: assert property (rsp_valid && rsp_last && fc_r == 8'h17 && !err_r |->
    rsp_idx_r == {rq_r[6:0], 1'b0} + 8'h01) else $error("combined length wrong");
  queue_bc_a: assert property (rsp_valid && rsp_idx_r == 8'h04 && fc_r == 8'h18 && !err_r |->
    bc_r == {rsp_data[6:0], 1'b0} + 8'h02) else $error("queue count mismatch");
  queue_max_a: assert property (rsp_valid && rsp_idx_r == 8'h04 && fc_r == 8'h18 && !err_r |->
    rsp_data <= 8'h1f) else $error("queue count above limit");
  queue_len_a: assert property (rsp_valid && rsp_last && fc_r == 8'h18 && !err_r |->
    rsp_idx_r == bc_r + 8'h02) else $error("queue length wrong");
  mei_type_a: assert property (mei_valid |-> mei_type inside {8'h0d, 8'h0e})
    else $error("reserved type forwarded");
  mei_route_a: assert property (mei_valid |-> mei_sel_b == (mei_type == 8'h0e))
    else $error("forward routed to wrong handler");
  mei_excl_a: assert property (rsp_valid && rsp_idx_r == 8'h00 && fc_r == 8'h2b |->
    rsp_data == 8'hab) else $error("transport answered itself");
  answer_a: assert property (req_valid && req_ready && req_last && fc_r != 8'h2b |->
    ##[1:40] rsp_valid) else $error("no answer to request");
  cover property (rsp_valid && rsp_last && fc_r == 8'h18 && !err_r);
  cover property (rsp_valid && rsp_idx_r == 8'h01 && err_r);
  cover property (mei_valid && mei_last);
  cover property (rsp_valid && !rsp_ready);
endmodule
bind register_function_handler rfh_checker u_rfh_checker (
  .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .req_valid(req_valid),
  .req_ready(req_ready), .req_data(req_data), .req_last(req_last), .rsp_valid(rsp_valid),
  .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last), .mei_valid(mei_valid),
  .mei_type(mei_type), .mei_data(mei_data), .mei_last(mei_last), .mei_sel_b(mei_sel_b));
`default_nettype wire

/* File: dv/client_model.sv */
// Request source and response sink standing in for the remote client.
`timescale 1ns/10ps
`default_nettype none
module client_model (
  // Clocking.
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Request stream.
  output var  logic       req_valid,
  input  wire logic       req_ready,
  output var  logic [7:0] req_data,
  output var  logic       req_last,
  // Response stream.
  input  wire logic       rsp_valid,
  output var  logic       rsp_ready,
  input  wire logic [7:0] rsp_data,
  input  wire logic       rsp_last
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic       slow = 1'b0;
  int         frames;
  // A byte is held until taken; an idle bus flips so no stale byte looks valid.
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_valid <= 1'b0;
      req_data  <= 8'h00;
      req_last  <= 1'b0;
      rsp_ready <= 1'b0;
      frames    <= 0;
    end
    else
    begin
      if (!req_valid || req_ready)
      begin
        req_valid <= (tx_q.size() > 0);
        req_data  <= (tx_q.size() > 0) ? tx_q.pop_front() : ~req_data;
        req_last  <= (tx_q.size() == 0) && req_valid !== 1'bx;
      end
      rsp_ready <= slow ? ~rsp_ready : 1'b1; // A slow sink stalls every other cycle.
      if (rsp_valid && rsp_ready)
      begin
        rx_q.push_back(rsp_data);
        if (rsp_last) frames <= frames + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/test_register_function_handler.sv */
// Self-checking bench for the register function handler.
`timescale 1ns/10ps
`default_nettype none
module test_register_function_handler;
  logic       core_clk;
  logic       rstn;
  logic       clk_en;
  logic       req_valid;
  logic       req_ready;
  logic [7:0] req_data;
  logic       req_last;
  logic       rsp_valid;
  logic       rsp_ready;
  logic [7:0] rsp_data;
  logic       rsp_last;
  logic       mei_valid;
  logic [7:0] mei_type;
  logic [7:0] mei_data;
  logic       mei_last;
  logic       mei_sel_b;
  logic [7:0] mei_q[$];
  logic [7:0] mt_seen;
  logic       sel_seen;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cycles = 0;
  register_function_handler u_register_function_handler (
    .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .req_valid(req_valid),
    .req_ready(req_ready), .req_data(req_data), .req_last(req_last), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last), .mei_valid(mei_valid),
    .mei_type(mei_type), .mei_data(mei_data), .mei_last(mei_last), .mei_sel_b(mei_sel_b));
  client_model u_client (
    .core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
    .req_data(req_data), .req_last(req_last), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .rsp_last(rsp_last));
  always #2.5 core_clk = ~core_clk;
  // Forwarded payload is collected here; the pulse lasts one cycle only.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      wrap_up();
    end
    if (mei_valid)
    begin
      mei_q.push_back(mei_data);
      mt_seen = mei_type;
      sel_seen = mei_sel_b;
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_num(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // One request out, whole answer compared; an empty answer waits a short fixed time.
  task automatic xact(input logic [511:0] rq, input int rn, input logic [511:0] ex, input int en);
    int f;
    int i;
    @(negedge core_clk);
    f = u_client.frames;
    u_client.rx_q.delete();
    for (i = rn - 1; i >= 0; i--) u_client.tx_q.push_back(rq[8*i +: 8]);
    for (i = 0; i < (en > 0 ? 400 : 60) && u_client.frames == f; i++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    check_num("response length", en, u_client.rx_q.size());
    for (i = 0; i < en && i < u_client.rx_q.size(); i++)
      check_byte("response byte", ex[8*(en-1-i) +: 8], u_client.rx_q[i]);
  endtask
  task automatic t_mask;
    xact(96'h17_0004_0001_0004_0001_02_0012, 12, 32'h17_02_0012, 4);
    xact(56'h16_0004_00f2_0025, 7, 56'h16_0004_00f2_0025, 7);
    xact(96'h17_0004_0001_0005_0001_02_0000, 12, 32'h17_02_0017, 4);
    $display("test mask done");
  endtask
  task automatic t_rw;
    xact(128'h17_000e_0003_000e_0003_06_1111_2222_3333, 16, 64'h17_06_1111_2222_3333, 8);
    xact(96'h17_00ff_0001_00ff_0001_02_beef, 12, 32'h17_02_beef, 4);
    xact(96'h17_00ff_0002_0000_0001_02_0000, 12, 16'h97_02, 2);
    xact(56'h16_0100_ffff_0000, 7, 16'h96_02, 2);
    xact(24'h05_0000, 3, 16'h85_01, 2);
    $display("test combined done");
  endtask
  task automatic t_errors;
    logic [95:0] bad [5];
    int          i;
    bad = '{96'h17_0000_0000_0000_0001_02_0000, 96'h17_0000_007e_0000_0001_02_0000,
            96'h17_0000_0001_0000_0000_02_0000, 96'h17_0000_0001_0000_007a_02_0000,
            96'h17_0000_0001_0000_0001_03_0000};
    for (i = 0; i < 5; i++) xact(bad[i], 12, 16'h97_03, 2);
    $display("test limits done");
  endtask
  task automatic t_queue;
    xact(128'h17_0020_0001_0020_0003_06_0002_01b8_1284, 16, 32'h17_02_0002, 4);
    xact(24'h18_0020, 3, 72'h18_0006_0002_01b8_1284, 9);
    u_client.slow = 1'b1;
    xact(24'h18_0020, 3, 72'h18_0006_0002_01b8_1284, 9);
    u_client.slow = 1'b0;
    xact(96'h17_0030_0001_0030_0001_02_0020, 12, 32'h17_02_0020, 4);
    xact(24'h18_0030, 3, 16'h98_03, 2);
    xact(96'h17_0030_0001_0030_0001_02_0000, 12, 32'h17_02_0000, 4);
    xact(24'h18_0030, 3, 40'h18_0002_0000, 5);
    $display("test queue done");
  endtask
  task automatic t_mei;
    logic [7:0] bad [4];
    int         i;
    bad = '{8'h0c, 8'h0f, 8'h00, 8'hff};
    for (i = 0; i < 2; i++)
    begin
      mei_q.delete();
      xact({8'h2b, 8'h0d + i[7:0], 16'h5aa5}, 4, 0, 0);
      check_num("forward length", 2, mei_q.size());
      check_byte("forward type", 8'h0d + i[7:0], mt_seen);
      check_byte("forward select", {7'h00, i[0]}, {7'h00, sel_seen});
    end
    for (i = 0; i < 4; i++)
    begin
      mei_q.delete();
      xact({8'h2b, bad[i], 8'h01}, 3, 16'hab_01, 2);
      check_num("forward length", 0, mei_q.size());
    end
    $display("test transport done");
  endtask
  initial
  begin
    core_clk = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    t_mask();
    t_rw();
    t_errors();
    t_queue();
    t_mei();
    wrap_up();
  end
endmodule
`default_nettype wire
